// ---- rtl/escs_cmd.sv ----
// command decoder and status reporter of the serial parameter channel
`timescale 1ns/1ns
`include "escs_defs.svh"
module escs_cmd #(
  parameter logic [7:0] MODEL_ID = 8'h3a, // arbitrary value
  parameter logic [7:0] MODEL_ID_MT = 8'h3b // arbitrary value
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_multiturn, // variant strap
  input wire logic i_frame_valid, // one-cycle: frame fields valid
  input wire logic [7:0] i_opcode,
  input wire logic [3:0] i_nbytes, // data bytes received
  input wire logic [7:0] i_arg0, // first data byte
  input wire logic [7:0] i_arg1,
  input wire logic [7:0] i_arg2,
  input wire logic [7:0] i_code0, // protection byte in frame
  input wire logic i_parity_err,
  input wire logic i_csum_err,
  input wire logic i_wdog_restart, // level from monitor after restart
  input wire logic [5:0] i_init_fault,
  input wire logic [5:0] i_run_fault, // amon,txcur,temp,speed,stpos,ovf
  output logic o_reply_valid, // one-cycle pulse
  output logic [7:0] o_reply0,
  output logic [7:0] o_reply1,
  output logic [7:0] o_status, // current latched status
  output logic o_exec, // one-cycle: command executed
  output logic [7:0] o_exec_op,
  output logic [7:0] o_code0 // current protection byte
);
  typedef struct packed {
    escs_pkg::escs_state_e fsm;
    logic mt; // strap caught after reset
    logic strap_done;
    logic [7:0] op;
    logic [3:0] nb;
    logic [7:0] a0;
    logic [7:0] a1;
    logic [7:0] a2;
    logic [7:0] pc;
    logic [7:0] err; // protocol/data error latch
    logic [7:0] code0;
    logic [7:0] free_mem;
    logic [3:0] field_cnt; // fields created so far
    logic [3:0] wprot; // per-field write protection
    logic rvalid;
    logic [7:0] r0;
    logic [7:0] r1;
    logic exec;
    logic [7:0] exop;
    logic [7:0] status;
  } escs_cmd_s;
  escs_cmd_s st;
  escs_cmd_s next_st;
  logic fault_any;
  logic [7:0] fault_code;
  logic [6:0] env;
  assign env = {i_wdog_restart, i_run_fault};
  // persistent device faults encoded apart from protocol errors
  escs_fault_prio u_prio (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_init_fault(i_init_fault),
    .i_env_fault({1'b0, env}),
    .o_any(fault_any),
    .o_code(fault_code)
  );
  // expected data byte count per opcode; 4'hf marks unknown opcode
  function automatic logic [3:0] exp_len(input logic [7:0] op);
    case (op)
      `ESCS_OP_READ_POS, `ESCS_OP_READ_CNT, `ESCS_OP_INC_CNT,
      `ESCS_OP_FREE_MEM, `ESCS_OP_READ_STATUS, `ESCS_OP_TYPE_LABEL,
      `ESCS_OP_RESET, `ESCS_OP_SERIAL_NO: exp_len = 4'h0;
      `ESCS_OP_READ_ANALOG, `ESCS_OP_FIELD_STAT: exp_len = 4'h1;
      `ESCS_OP_DEL_CNT: exp_len = 4'h1;
      `ESCS_OP_READ_DATA: exp_len = 4'h2;
      `ESCS_OP_STORE_DATA: exp_len = 4'h3;
      `ESCS_OP_CREATE_FIELD, `ESCS_OP_CHANGE_CODE: exp_len = 4'h2;
      `ESCS_OP_SET_POS, `ESCS_OP_SET_ADDR, `ESCS_OP_CFG_IF: exp_len = 4'h1;
      default: exp_len = 4'hf;
    endcase
  endfunction : exp_len
  // opcodes that carry the extra protection byte
  function automatic logic needs_code0(input logic [7:0] op);
    needs_code0 = (op == `ESCS_OP_SET_POS) || (op == `ESCS_OP_SET_ADDR) ||
      (op == `ESCS_OP_CFG_IF);
  endfunction : needs_code0
  // field numbers are 0..count-1; used by several opcodes
  function automatic logic field_ok(input logic [7:0] f,
                                    input logic [3:0] cnt);
    field_ok = (f < {4'h0, cnt});
  endfunction : field_ok
  // one pass: take frame, check, execute or reject, then reply
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.exec = 1'b0;
    // strap is sampled once after release, never under reset
    if (!st.strap_done) begin
      next_st.mt = i_multiturn;
      next_st.strap_done = 1'b1;
    end
    unique case (st.fsm)
      escs_pkg::ST_IDLE: begin
        if (i_frame_valid) begin
          next_st.op = i_opcode;
          next_st.nb = i_nbytes;
          next_st.a0 = i_arg0;
          next_st.a1 = i_arg1;
          next_st.a2 = i_arg2;
          next_st.pc = i_code0;
          // frame errors stop here and execute nothing
          if (i_parity_err) begin
            next_st.err = `ESCS_ST_PARITY;
          end else if (i_csum_err) begin
            next_st.err = `ESCS_ST_CSUM;
          end else begin
            next_st.fsm = escs_pkg::ST_CHECK;
          end
        end
      end
      escs_pkg::ST_CHECK: begin
        next_st.fsm = escs_pkg::ST_IDLE;
        if (exp_len(st.op) == 4'hf) begin
          next_st.err = `ESCS_ST_UNK_CMD;
        end else if (exp_len(st.op) != st.nb) begin
          next_st.err = `ESCS_ST_LEN;
        end else if (needs_code0(st.op) && st.pc != st.code0) begin
          next_st.err = `ESCS_ST_ACODE;
        end else begin
          next_st.fsm = escs_pkg::ST_EXEC;
        end
      end
      escs_pkg::ST_EXEC: begin
        next_st.fsm = escs_pkg::ST_REPLY;
        next_st.r0 = 8'h00;
        next_st.r1 = 8'h00;
        unique case (st.op)
          `ESCS_OP_TYPE_LABEL: begin
            next_st.r0 = st.mt ? MODEL_ID_MT : MODEL_ID;
          end
          `ESCS_OP_READ_STATUS: begin
            next_st.r0 = st.status;
            next_st.err = `ESCS_ST_OK; // reading clears the error latch
          end
          `ESCS_OP_FIELD_STAT: begin
            if (!field_ok(st.a0, st.field_cnt)) begin
              next_st.err = `ESCS_ST_NOFIELD;
              next_st.fsm = escs_pkg::ST_IDLE;
            end else begin
              next_st.r0 = {7'h00, st.wprot[st.a0[1:0]]};
              next_st.r1 = `ESCS_FIELD_WORDS;
            end
          end
          `ESCS_OP_FREE_MEM: begin
            next_st.r0 = st.free_mem;
          end
          `ESCS_OP_READ_DATA, `ESCS_OP_STORE_DATA: begin
            if (!field_ok(st.a0, st.field_cnt)) begin
              next_st.err = `ESCS_ST_NOFIELD;
              next_st.fsm = escs_pkg::ST_IDLE;
            end else if (st.a1 >= `ESCS_FIELD_WORDS) begin
              next_st.err = `ESCS_ST_WADDR;
              next_st.fsm = escs_pkg::ST_IDLE;
            end else if (st.op == `ESCS_OP_STORE_DATA &&
                         st.wprot[st.a0[1:0]]) begin
              next_st.err = `ESCS_ST_WPROT;
              next_st.fsm = escs_pkg::ST_IDLE;
            end
          end
          `ESCS_OP_CREATE_FIELD: begin
            // existing fields keep their size
            if (field_ok(st.a0, st.field_cnt)) begin
              next_st.err = `ESCS_ST_FIXSIZE;
              next_st.fsm = escs_pkg::ST_IDLE;
            end else if (st.a0 != {4'h0, st.field_cnt} ||
                         st.field_cnt == `ESCS_NUM_FIELDS ||
                         st.free_mem < `ESCS_FIELD_WORDS) begin
              next_st.err = `ESCS_ST_ARG;
              next_st.fsm = escs_pkg::ST_IDLE;
            end else begin
              next_st.field_cnt = st.field_cnt + 4'h1;
              next_st.free_mem = st.free_mem - `ESCS_FIELD_WORDS;
              next_st.wprot[st.a0[1:0]] = st.a1[0];
            end
          end
          `ESCS_OP_CHANGE_CODE: begin
            if (st.a0 != st.code0) begin
              next_st.err = `ESCS_ST_ACODE;
              next_st.fsm = escs_pkg::ST_IDLE;
            end else begin
              next_st.code0 = st.a1;
            end
          end
          `ESCS_OP_READ_ANALOG: begin
            // only the temperature channel is offered
            if (st.a0 != 8'h48) begin
              next_st.err = `ESCS_ST_ARG;
              next_st.fsm = escs_pkg::ST_IDLE;
            end
          end
          default: begin
            next_st.r0 = 8'h00; // handled by the outside datapath
          end
        endcase
      end
      escs_pkg::ST_REPLY: begin
        next_st.fsm = escs_pkg::ST_IDLE;
        next_st.rvalid = 1'b1;
        next_st.exec = 1'b1;
        next_st.exop = st.op;
      end
    endcase
    // device faults are latched too; one still present re-sets the
    // latch after a status read, so the set wins over the clear
    if (fault_any) begin
      next_st.err = fault_code;
    end
    next_st.status = next_st.err;
  end
  // single state register
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
      st.code0 <= `ESCS_CODE0_RST;
      st.free_mem <= `ESCS_FREE_MEM_RST;
    end else begin
      st <= next_st;
    end
  end
  assign o_reply_valid = st.rvalid;
  assign o_reply0 = st.r0;
  assign o_reply1 = st.r1;
  assign o_status = st.status;
  assign o_exec = st.exec;
  assign o_exec_op = st.exop;
  assign o_code0 = st.code0;
endmodule : escs_cmd

// ---- rtl/escs_fault_prio.sv ----
// priority selector of environmental and init fault codes
`timescale 1ns/1ns
`include "escs_defs.svh"
module escs_fault_prio (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [5:0] i_init_fault, // align,offset,ptable,alim,i2c,csum
  input wire logic [7:0] i_env_fault, // see code map below
  output logic o_any,
  output logic [7:0] o_code
);
  typedef struct packed {
    logic any;
    logic [7:0] code;
  } escs_prio_s;
  escs_prio_s st;
  escs_prio_s next_st;
  // lowest-index init fault and highest-index env fault win; init faults outrank runtime faults
  always_comb begin
    next_st = '0;
    // env: 0 amon,1 txcur,2 temp,3 speed,4 stpos,5 cnt ovf,6 wdog
    if (i_env_fault[6]) begin
      next_st.code = `ESCS_ST_WDOG;
    end else if (i_env_fault[5]) begin
      next_st.code = `ESCS_ST_CNT_OVF;
    end else if (i_env_fault[4]) begin
      next_st.code = `ESCS_ST_STPOS;
    end else if (i_env_fault[3]) begin
      next_st.code = `ESCS_ST_SPEED;
    end else if (i_env_fault[2]) begin
      next_st.code = `ESCS_ST_TEMP;
    end else if (i_env_fault[1]) begin
      next_st.code = `ESCS_ST_TXCUR;
    end else if (i_env_fault[0]) begin
      next_st.code = `ESCS_ST_AMON;
    end
    // init faults override, last one found (lowest index) counts
    for (int k = 5; k >= 0; k--) begin
      if (i_init_fault[k]) begin
        next_st.code = 8'(k + 1);
      end
    end
    next_st.any = |{i_init_fault, i_env_fault[6:0]};
  end
  // registered so the code is stable a cycle after the fault
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_any = st.any;
  assign o_code = st.code;
endmodule : escs_fault_prio

// ---- shared/escs_defs.svh ----
// opcode, status code, field size and reset value constants for the command block
`ifndef ESCS_DEFS_SVH
`define ESCS_DEFS_SVH
`define ESCS_OP_READ_POS 8'h42
`define ESCS_OP_SET_POS 8'h43
`define ESCS_OP_READ_ANALOG 8'h44
`define ESCS_OP_READ_CNT 8'h46
`define ESCS_OP_INC_CNT 8'h47
`define ESCS_OP_DEL_CNT 8'h49
`define ESCS_OP_READ_DATA 8'h4a
`define ESCS_OP_STORE_DATA 8'h4b
`define ESCS_OP_FIELD_STAT 8'h4c
`define ESCS_OP_CREATE_FIELD 8'h4d
`define ESCS_OP_FREE_MEM 8'h4e
`define ESCS_OP_CHANGE_CODE 8'h4f
`define ESCS_OP_READ_STATUS 8'h50
`define ESCS_OP_TYPE_LABEL 8'h52
`define ESCS_OP_RESET 8'h53
`define ESCS_OP_SET_ADDR 8'h55
`define ESCS_OP_SERIAL_NO 8'h56
`define ESCS_OP_CFG_IF 8'h57
`define ESCS_ST_OK 8'h00
`define ESCS_ST_ALIGN 8'h01
`define ESCS_ST_OFFSET 8'h02
`define ESCS_ST_PTABLE 8'h03
`define ESCS_ST_ALIMIT 8'h04
`define ESCS_ST_I2C 8'h05
`define ESCS_ST_ICSUM 8'h06
`define ESCS_ST_WDOG 8'h07
`define ESCS_ST_CNT_OVF 8'h08
`define ESCS_ST_PARITY 8'h09
`define ESCS_ST_CSUM 8'h0a
`define ESCS_ST_UNK_CMD 8'h0b
`define ESCS_ST_LEN 8'h0c
`define ESCS_ST_ARG 8'h0d
`define ESCS_ST_WPROT 8'h0e
`define ESCS_ST_ACODE 8'h0f
`define ESCS_ST_FIXSIZE 8'h10
`define ESCS_ST_WADDR 8'h11
`define ESCS_ST_NOFIELD 8'h12
`define ESCS_ST_AMON 8'h1c
`define ESCS_ST_TXCUR 8'h1d
`define ESCS_ST_TEMP 8'h1e
`define ESCS_ST_SPEED 8'h1f
`define ESCS_ST_STPOS 8'h20
`define ESCS_CODE0_RST 8'h55
`define ESCS_NUM_FIELDS 4'h4
`define ESCS_FIELD_WORDS 8'h10
`define ESCS_FREE_MEM_RST 8'h80
`endif

// ---- shared/escs_pkg.sv ----
// types shared by the command block
package escs_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_EXEC = 2'b10,
    ST_REPLY = 2'b11
  } escs_state_e;
  typedef logic [7:0] escs_byte_t;
endpackage : escs_pkg

// ---- tb/escs_cmd_assertions.sv ----
// port-level checker of the command block
`timescale 1ns/1ns
`include "escs_defs.svh"
module escs_cmd_assertions #(
  parameter logic [7:0] MODEL_ID = 8'h3a, // arbitrary value
  parameter logic [7:0] MODEL_ID_MT = 8'h3b // arbitrary value
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_multiturn,
  input wire logic i_frame_valid,
  input wire logic [7:0] i_opcode,
  input wire logic [3:0] i_nbytes,
  input wire logic [7:0] i_arg0,
  input wire logic [7:0] i_arg1,
  input wire logic [7:0] i_arg2,
  input wire logic [7:0] i_code0,
  input wire logic i_parity_err,
  input wire logic i_csum_err,
  input wire logic i_wdog_restart,
  input wire logic [5:0] i_init_fault,
  input wire logic [5:0] i_run_fault,
  input wire logic o_reply_valid,
  input wire logic [7:0] o_reply0,
  input wire logic [7:0] o_reply1,
  input wire logic [7:0] o_status,
  input wire logic o_exec,
  input wire logic [7:0] o_exec_op,
  input wire logic [7:0] o_code0
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // device faults hide protocol codes, so protocol checks need quiet
  wire logic quiet = i_init_fault == 6'h00 && i_run_fault == 6'h00
    && !i_wdog_restart;
  wire logic ok_frame = i_frame_valid && !i_parity_err && !i_csum_err
    && quiet;
  wire logic bad_frame = i_frame_valid && (i_parity_err || i_csum_err);
  // executed frame: one reply pulse, with exec, then silence
  sequence s_type_reply;
    ##[1:5] (o_reply_valid && (o_reply0 == MODEL_ID
      || o_reply0 == MODEL_ID_MT));
  endsequence
  sequence s_silent;
    !(o_exec || o_reply_valid) [*4];
  endsequence
  property p_type;
    ok_frame && i_opcode == `ESCS_OP_TYPE_LABEL && i_nbytes == 4'h0
      |-> s_type_reply;
  endproperty
  a_type: assert property (p_type)
    else $error("type label reply missing");
  property p_parity;
    i_frame_valid && i_parity_err && quiet
      |-> ##[1:4] o_status == `ESCS_ST_PARITY;
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity code missing");
  property p_csum;
    i_frame_valid && !i_parity_err && i_csum_err && quiet
      |-> ##[1:4] o_status == `ESCS_ST_CSUM;
  endproperty
  a_csum: assert property (p_csum)
    else $error("checksum code missing");
  property p_unknown;
    ok_frame && i_opcode inside {[8'h60:8'h7f]}
      |-> ##[1:5] o_status == `ESCS_ST_UNK_CMD;
  endproperty
  a_unknown: assert property (p_unknown)
    else $error("unknown opcode code missing");
  property p_silent;
    bad_frame |=> s_silent;
  endproperty
  a_silent: assert property (p_silent)
    else $error("failed frame was acted on");
  property p_pulse;
    o_reply_valid |-> o_exec ##1 !o_reply_valid;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("reply pulse malformed");
  property p_wdog;
    i_wdog_restart && i_init_fault == 6'h00
      |-> ##[1:3] o_status == `ESCS_ST_WDOG;
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog code missing");
  property p_init;
    i_init_fault[0] |-> ##[1:3] o_status == `ESCS_ST_ALIGN;
  endproperty
  a_init: assert property (p_init)
    else $error("alignment code missing");
  // protection byte moves only around an executed command
  property p_code0;
    $changed(o_code0) |-> ##1 o_exec;
  endproperty
  a_code0: assert property (p_code0)
    else $error("protection byte changed without command");
endmodule : escs_cmd_assertions

// ---- tb/escs_cmd_tb.sv ----
// self-checking bench of the command block
`timescale 1ns/1ns
`include "escs_defs.svh"
module escs_cmd_tb;
  localparam logic [7:0] ID_ST = 8'h3a; // arbitrary value
  localparam logic [7:0] ID_MT = 8'h3b; // arbitrary value
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_multiturn = 1'b0;
  logic i_wdog_restart = 1'b0;
  logic [5:0] i_init_fault = 6'h00;
  logic [5:0] i_run_fault = 6'h00;
  logic i_frame_valid, i_parity_err, i_csum_err, o_reply_valid, o_exec;
  logic [3:0] i_nbytes;
  logic [7:0] i_opcode, i_arg0, i_code0, o_reply0, o_status, o_code0;
  logic [7:0] i_arg1, o_reply1, o_exec_op;
  logic [7:0] exp_q[$]; // expected reply bytes, oldest first
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  // error frames: opcode, count, arg, error bits, status code
  logic [7:0] t_op[7] = '{8'h52, 8'h52, 8'h60, 8'h52, 8'h44, 8'h4f, 8'h4c};
  logic [3:0] t_n[7] = '{4'h0, 4'h0, 4'h0, 4'hf, 4'h1, 4'h2, 4'h1};
  logic [7:0] t_a[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h47, 8'h54, 8'h07};
  logic [1:0] t_e[7] = '{2'b01, 2'b10, 2'b00, 2'b00, 2'b00, 2'b00, 2'b00};
  logic [7:0] t_c[7] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0f, 8'h12};
  logic [7:0] f_c[12] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h08};
  always #20 i_sys_clk = ~i_sys_clk;
  escs_ctrl_model m_u (.i_sys_clk, .o_frame_valid(i_frame_valid),
    .o_opcode(i_opcode), .o_nbytes(i_nbytes), .o_arg0(i_arg0),
    .o_arg1(i_arg1),
    .o_code0(i_code0), .o_parity_err(i_parity_err),
    .o_csum_err(i_csum_err));
  escs_cmd #(.MODEL_ID(ID_ST), .MODEL_ID_MT(ID_MT)) dut_u (.i_sys_clk,
    .i_rstn, .i_multiturn, .i_frame_valid, .i_opcode, .i_nbytes, .i_arg0,
    .i_arg1, .i_arg2(8'h00), .i_code0, .i_parity_err, .i_csum_err,
    .i_wdog_restart, .i_init_fault, .i_run_fault, .o_reply_valid,
    .o_reply0, .o_reply1, .o_status, .o_exec, .o_exec_op, .o_code0);
  task automatic chk(input string what, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  // reply watcher, sampled mid-cycle once outputs have settled
  always @(negedge i_sys_clk) begin
    if (o_reply_valid === 1'b1) begin
      chk("reply0", exp_q.size() ? exp_q.pop_front() : ~o_reply0,
        o_reply0);
    end
  end
  // hang guard
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic reset_dut(input logic mt);
    i_rstn = 1'b0;
    i_multiturn = mt;
    repeat (3) @(posedge i_sys_clk);
    #2;
    i_rstn = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #2;
  endtask : reset_dut
  // read status: reply carries the code, then the latch is empty
  task automatic read_clear(input logic [7:0] code);
    exp_q.push_back(code);
    m_u.send(`ESCS_OP_READ_STATUS, 4'h0, 8'h00, 2'b00);
    chk("status cleared", `ESCS_ST_OK, o_status);
  endtask : read_clear
  initial begin
    void'($urandom(32'h66d7));
    t_op[2] = 8'h60 + 8'($urandom_range(31));
    reset_dut(1'b0);
    chk("code0 reset", 8'h55, o_code0);
    chk("status reset", `ESCS_ST_OK, o_status);
    exp_q.push_back(ID_ST);
    m_u.send(`ESCS_OP_TYPE_LABEL, 4'h0, 8'h00, 2'b00);
    exp_q.push_back(`ESCS_FREE_MEM_RST);
    m_u.send(`ESCS_OP_FREE_MEM, 4'h0, 8'h00, 2'b00);
    $display("test basic done");
    for (int i = 0; i < 7; i++) begin
      m_u.send(t_op[i], t_n[i], t_a[i], t_e[i]);
      chk("error status", t_c[i], o_status);
      chk("code0 kept", 8'h55, o_code0);
      read_clear(t_c[i]);
    end
    $display("test frame errors done");
    for (int i = 0; i < 12; i++) begin
      if (i < 6) i_init_fault = 6'h01 << i;
      else i_run_fault = 6'h01 << (i - 6);
      repeat (4) @(posedge i_sys_clk);
      #2;
      chk("fault status", f_c[i], o_status);
      i_init_fault = 6'h00;
      i_run_fault = 6'h00;
      read_clear(f_c[i]);
    end
    i_run_fault = 6'($urandom_range(63));
    i_init_fault = 6'h34;
    repeat (4) @(posedge i_sys_clk);
    #2;
    chk("init priority", `ESCS_ST_PTABLE, o_status);
    i_init_fault = 6'h00;
    i_run_fault = 6'h20;
    i_wdog_restart = 1'b1;
    repeat (4) @(posedge i_sys_clk);
    #2;
    chk("watchdog", `ESCS_ST_WDOG, o_status);
    i_wdog_restart = 1'b0;
    i_run_fault = 6'h00;
    $display("test faults done");
    reset_dut(1'b1);
    exp_q.push_back(ID_MT);
    m_u.send(`ESCS_OP_TYPE_LABEL, 4'h0, 8'h00, 2'b00);
    // field zero created write protected, then data errors on it
    exp_q.push_back(8'h00);
    m_u.send(`ESCS_OP_CREATE_FIELD, 4'h2, 8'h00, 2'b00, 8'h01);
    chk("exec op", `ESCS_OP_CREATE_FIELD, o_exec_op);
    exp_q.push_back(8'h01);
    m_u.send(`ESCS_OP_FIELD_STAT, 4'h1, 8'h00, 2'b00);
    chk("field words", `ESCS_FIELD_WORDS, o_reply1);
    exp_q.push_back(8'h70);
    m_u.send(`ESCS_OP_FREE_MEM, 4'h0, 8'h00, 2'b00);
    m_u.send(`ESCS_OP_STORE_DATA, 4'h3, 8'h00, 2'b00, 8'h00);
    chk("write protect", `ESCS_ST_WPROT, o_status);
    read_clear(`ESCS_ST_WPROT);
    m_u.send(`ESCS_OP_CREATE_FIELD, 4'h2, 8'h00, 2'b00, 8'h00);
    chk("fixed size", `ESCS_ST_FIXSIZE, o_status);
    read_clear(`ESCS_ST_FIXSIZE);
    m_u.send(`ESCS_OP_READ_DATA, 4'h2, 8'h00, 2'b00, 8'h10);
    chk("word address", `ESCS_ST_WADDR, o_status);
    read_clear(`ESCS_ST_WADDR);
    exp_q.push_back(8'h00);
    m_u.send(`ESCS_OP_CHANGE_CODE, 4'h2, 8'h55, 2'b00, 8'h5a);
    chk("code0 changed", 8'h5a, o_code0);
    chk("replies left", 8'h00, 8'(exp_q.size()));
    $display("test variant done");
    test_done();
  end
endmodule : escs_cmd_tb
bind escs_cmd escs_cmd_assertions #(.MODEL_ID(MODEL_ID),
  .MODEL_ID_MT(MODEL_ID_MT)) chk_u (.*);

// ---- tb/escs_ctrl_model.sv ----
// drive controller model: sends whole command frames
`timescale 1ns/1ns
module escs_ctrl_model (
  input wire logic i_sys_clk,
  output logic o_frame_valid,
  output logic [7:0] o_opcode,
  output logic [3:0] o_nbytes,
  output logic [7:0] o_arg0,
  output logic [7:0] o_arg1,
  output logic [7:0] o_code0,
  output logic o_parity_err,
  output logic o_csum_err
);
  initial begin
    o_frame_valid = 1'b0;
    o_opcode = 8'h00;
    o_nbytes = 4'h0;
    o_arg0 = 8'h00;
    o_arg1 = 8'h00;
    o_code0 = 8'h00;
    o_parity_err = 1'b0;
    o_csum_err = 1'b0;
  end
  // one frame, then fields scrambled and a gap well over the minimum
  task automatic send(input logic [7:0] op, input logic [3:0] n,
    input logic [7:0] a0, input logic [1:0] err,
    input logic [7:0] a1 = 8'h00);
    @(posedge i_sys_clk);
    #2;
    o_frame_valid = 1'b1;
    o_opcode = op;
    o_nbytes = n;
    o_arg0 = a0;
    o_arg1 = a1;
    o_code0 = 8'h55; // protection byte always inserted
    o_parity_err = err[0];
    o_csum_err = err[1];
    @(posedge i_sys_clk);
    #2;
    o_frame_valid = 1'b0;
    o_opcode = ~op; // stale opcode, args and code0 never hold their value
    o_arg0 = ~a0;
    o_arg1 = ~a1;
    o_code0 = 8'haa;
    repeat (6) @(posedge i_sys_clk);
    #2;
  endtask : send
endmodule : escs_ctrl_model
